// >>> verilog/apdu_cmd_pkg.sv
package apdu_cmd_pkg;
  // command kinds, decoded upstream from the instruction byte
  typedef enum logic [2:0] {
    cmd_other_type      = 3'h0,
    cmd_challenge_type  = 3'h1,
    cmd_profile_type    = 3'h2,
    cmd_envelope_type   = 3'h3,
    cmd_fetch_type      = 3'h4,
    cmd_term_resp_type  = 3'h5,
    cmd_get_resp_type   = 3'h6
  } cmd_kind_type;

  // status words answered by this block
  localparam logic [15:0] SW_OK            = 16'h9000;
  localparam logic [15:0] SW_TECH_PROBLEM  = 16'h6f00;
  localparam logic [15:0] SW_WRONG_PARAM   = 16'h6b00;
  localparam logic [7:0]  SW1_MORE_DATA    = 8'h61;
  localparam logic [7:0]  PARAM_ZERO       = 8'h00;
  localparam int          CHAN_W           = 2;
  localparam int          NUM_CHAN         = 4;
  localparam int          RAND_W           = 8;
  localparam int          RAND_MAX_BYTES   = 8;
  localparam logic [7:0]  LE_ZERO          = 8'h00;
  localparam logic [7:0]  RAND_MAX_LEN     = 8'h08;
  localparam logic [15:0] LFSR_SEED        = 16'hace1;
  localparam logic [15:0] LFSR_TAPS        = 16'hb400;
  // class byte field holding the logical channel
  localparam int          CLA_CHAN_LSB     = 0;
endpackage : apdu_cmd_pkg

// >>> verilog/rand_lfsr.sv
`timescale 1ns/100ps
// free-running galois lfsr; quality is an application concern
module rand_lfsr
  import apdu_cmd_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  output logic [15:0]      state_out
);
  logic [15:0] lfsr_reg;
  wire  [15:0] lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ LFSR_TAPS)
                                       : (lfsr_reg >> 1);

  // advances every cycle so each challenge picks up fresh bits
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) lfsr_reg <= LFSR_SEED;
    else             lfsr_reg <= lfsr_next;
  end

  assign state_out = lfsr_reg;
endmodule : rand_lfsr

// >>> verilog/card_apdu_command_handler.sv
`timescale 1ns/100ps
module card_apdu_command_handler
  import apdu_cmd_pkg::*;
(
  input  wire logic               mclk_in,
  input  wire logic               reset_n_in,
  input  wire logic               cmd_valid_in,
  input  wire cmd_kind_type       cmd_kind_in,
  input  wire logic [7:0]         cla_in,
  input  wire logic [7:0]         p1_in,
  input  wire logic [7:0]         p2_in,
  input  wire logic [7:0]         le_in,
  input  wire logic               le_present_in,
  input  wire logic               proactive_valid_in,
  input  wire logic [7:0]         proactive_len_in,
  input  wire logic               envelope_len_valid_in,
  input  wire logic [7:0]         envelope_len_in,
  input  wire logic [CHAN_W-1:0]  ref_chan_in,
  output logic [RAND_W*RAND_MAX_BYTES-1:0] ref_rand_out,
  output logic                    ref_rand_valid_out,
  output logic                    resp_valid_out,
  output logic [15:0]             resp_sw_out,
  output logic [7:0]              resp_len_out,
  output logic                    resp_from_rand_out,
  output logic [RAND_W*RAND_MAX_BYTES-1:0] resp_rand_out,
  output logic                    pend_valid_out
);
  localparam int RW = RAND_W*RAND_MAX_BYTES;

  // per-channel random storage, kept until the next challenge there
  logic [RW-1:0]      rand_mem_reg [NUM_CHAN];
  logic [NUM_CHAN-1:0] rand_ok_reg;
  logic               pend_reg;
  logic [CHAN_W-1:0]  pend_chan_reg;
  logic [7:0]         pend_len_reg;
  logic               pend_rand_reg;
  logic               resp_valid_reg;
  logic [15:0]        resp_sw_reg;
  logic [7:0]         resp_len_reg;
  logic               resp_from_rand_reg;
  logic [RW-1:0]      resp_rand_reg;
  logic [15:0]        lfsr_state;
  logic [RW-1:0]      fresh_rand_reg;

  rand_lfsr u_rand (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .state_out  (lfsr_state)
  );

  // shift lfsr bits into a wide pool so successive words differ
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) fresh_rand_reg <= '0;
    else fresh_rand_reg <= {fresh_rand_reg[RW-17:0], lfsr_state};
  end

  // decode of the incoming command
  wire [CHAN_W-1:0] cmd_chan   = cla_in[CLA_CHAN_LSB +: CHAN_W];
  wire params_zero  = (p1_in == PARAM_ZERO) && (p2_in == PARAM_ZERO);
  wire is_chal      = cmd_valid_in && cmd_kind_in == cmd_challenge_type;
  wire is_getr      = cmd_valid_in && cmd_kind_in == cmd_get_resp_type;
  wire is_fetch     = cmd_valid_in && cmd_kind_in == cmd_fetch_type;
  wire is_env       = cmd_valid_in && cmd_kind_in == cmd_envelope_type;
  wire is_nodata    = cmd_valid_in && (cmd_kind_in == cmd_profile_type ||
                                       cmd_kind_in == cmd_term_resp_type);
  wire is_handled   = is_chal || is_getr || is_fetch || is_env || is_nodata;
  wire bad_param    = is_handled && !params_zero;
  // le of zero means maximum; cap random length at storage size
  wire [7:0] chal_len = (le_in == LE_ZERO || le_in > RAND_MAX_LEN)
                        ? RAND_MAX_LEN : le_in;
  // get response is good only straight after its command, same channel
  wire getr_ok      = pend_reg && (pend_chan_reg == cmd_chan);
  wire [7:0] getr_len = (le_in == LE_ZERO || le_in > pend_len_reg)
                        ? pend_len_reg : le_in;
  wire fetch_go     = is_fetch && params_zero && proactive_valid_in;
  wire [7:0] fetch_len = (le_present_in && le_in != LE_ZERO &&
                          le_in < proactive_len_in) ? le_in
                                                    : proactive_len_in;
  wire env_go       = is_env && params_zero && envelope_len_valid_in;
  wire new_pend     = (is_chal && params_zero) || fetch_go || env_go;
  wire [7:0] new_pend_len = is_chal ? chal_len :
                            (fetch_go ? fetch_len : envelope_len_in);

  // random storage per channel
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rand_ok_reg <= '0;
      for (int i = 0; i < NUM_CHAN; i++) rand_mem_reg[i] <= '0;
    end else if (is_chal && params_zero) begin
      rand_mem_reg[cmd_chan] <= fresh_rand_reg;
      rand_ok_reg[cmd_chan]  <= 1'b1;
    end
  end

  // pending response: any new command ends the old one
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_reg      <= 1'b0;
      pend_chan_reg <= '0;
      pend_len_reg  <= '0;
      pend_rand_reg <= 1'b0;
    end else if (cmd_valid_in) begin
      pend_reg      <= new_pend;
      pend_chan_reg <= cmd_chan;
      pend_len_reg  <= new_pend_len;
      pend_rand_reg <= is_chal;
    end
  end

  // next answer selection; get response before any command is harmless
  logic [15:0] sw_next;
  logic [7:0]  len_next;
  logic        from_rand_next;
  always_comb begin
    sw_next        = SW_OK;
    len_next       = '0;
    from_rand_next = 1'b0;
    if (bad_param) begin
      sw_next = SW_WRONG_PARAM;
    end else if (is_getr) begin
      if (getr_ok) begin
        len_next       = getr_len;
        from_rand_next = pend_rand_reg;
      end else begin
        sw_next = SW_TECH_PROBLEM;
      end
    end else if (new_pend) begin
      sw_next = {SW1_MORE_DATA, new_pend_len};
    end
  end

  // registered answer, one cycle after the command
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resp_valid_reg     <= 1'b0;
      resp_sw_reg        <= SW_OK;
      resp_len_reg       <= '0;
      resp_from_rand_reg <= 1'b0;
      resp_rand_reg      <= '0;
    end else begin
      resp_valid_reg     <= is_handled;
      resp_sw_reg        <= sw_next;
      resp_len_reg       <= len_next;
      resp_from_rand_reg <= from_rand_next;
      resp_rand_reg      <= rand_mem_reg[pend_chan_reg];
    end
  end

  assign resp_valid_out     = resp_valid_reg;
  assign resp_sw_out        = resp_sw_reg;
  assign resp_len_out       = resp_len_reg;
  assign resp_from_rand_out = resp_from_rand_reg;
  assign resp_rand_out      = resp_rand_reg;
  assign pend_valid_out     = pend_reg;
  // internal users see the latest number of the named channel
  assign ref_rand_out       = rand_mem_reg[ref_chan_in];
  assign ref_rand_valid_out = rand_ok_reg[ref_chan_in];

  a_bad_param_sw: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in) bad_param |=> resp_valid_out &&
    resp_sw_out == SW_WRONG_PARAM && resp_len_out == 8'h00)
    else $error("bad parameters not refused");
  a_getr_seq: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in) is_getr && params_zero && !getr_ok
    |=> resp_sw_out == SW_TECH_PROBLEM)
    else $error("out of sequence get response not refused");
  a_chal_pend: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in) is_chal && params_zero
    |=> pend_valid_out && resp_sw_out[15:8] == SW1_MORE_DATA
    && resp_sw_out[7:0] <= RAND_MAX_LEN)
    else $error("challenge did not announce data");
  a_len_cap: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in) is_getr && getr_ok && params_zero
    && le_in != 8'h00 |=> resp_len_out <= $past(le_in))
    else $error("response longer than le");
  a_chan_drop: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in) pend_valid_out && cmd_valid_in
    && cmd_chan != pend_chan_reg && !new_pend |=> !pend_valid_out)
    else $error("pending response kept across channel");
  a_rand_store: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in) is_chal && params_zero
    |=> rand_mem_reg[$past(cmd_chan)] == $past(fresh_rand_reg))
    else $error("random not bound to channel");
  a_rand_keep: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in) !is_chal |=> $stable(rand_ok_reg))
    else $error("random validity changed");
  a_nodata_len: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in) is_nodata |=> resp_len_out == 8'h00
    && !pend_valid_out)
    else $error("no-data command produced data");
  // a served get response must say ok and name the right data source
  a_getr_serve: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in) is_getr && getr_ok && params_zero
    |=> resp_sw_out == SW_OK && resp_from_rand_out == $past(pend_rand_reg))
    else $error("pending data not served");
  // main scenarios: challenge then retrieval, toolkit data, lost answers
  c_chal_getr: cover property (@(posedge mclk_in)
    disable iff (!reset_n_in) is_chal ##[1:2] is_getr && getr_ok);
  c_envelope: cover property (@(posedge mclk_in)
    disable iff (!reset_n_in) env_go);
  c_chan_lose: cover property (@(posedge mclk_in)
    disable iff (!reset_n_in) pend_valid_out && cmd_valid_in
    && cmd_chan != pend_chan_reg);
  c_fetch: cover property (@(posedge mclk_in)
    disable iff (!reset_n_in) fetch_go);
  c_tech: cover property (@(posedge mclk_in)
    disable iff (!reset_n_in) is_getr && !getr_ok);
endmodule : card_apdu_command_handler

// >>> verification/terminal_model.sv
`timescale 1ns/100ps
// terminal side: one command header per call, held for one clock
module terminal_model
  import apdu_cmd_pkg::*;
(
  input  wire logic   mclk_in,
  output logic         cmd_valid_out,
  output cmd_kind_type cmd_kind_out,
  output logic [7:0]   cla_out,
  output logic [7:0]   p1_out,
  output logic [7:0]   p2_out,
  output logic [7:0]   le_out,
  output logic         le_present_out
);
  // idle lines except le_present_out show a pattern, not the last value
  initial begin
    cmd_valid_out = 1'b0;
    cmd_kind_out = cmd_other_type;
    {cla_out, p1_out, p2_out, le_out, le_present_out} = '0;
  end
  // parameters are zero unless a refusal is asked for
  // callers place get response straight after its command, or out of order to test refusal
  task automatic issue(input cmd_kind_type kind, input logic [7:0] cla,
                       input logic bad, input logic [7:0] le,
                       input logic lep);
    @(posedge mclk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_kind_out = kind;
    cla_out = cla;
    p1_out = bad ? 8'h01 : PARAM_ZERO;
    p2_out = PARAM_ZERO;
    le_out = le;
    le_present_out = lep;
    @(posedge mclk_in);
    #1;
    cmd_valid_out = 1'b0;
    cmd_kind_out = cmd_other_type;
    {cla_out, p1_out, p2_out, le_out} = ~{cla_out, p1_out, p2_out, le_out};
  endtask : issue
endmodule : terminal_model

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
  import apdu_cmd_pkg::*;
  logic mclk_in = 1'b0, reset_n_in = 1'b0, cv, lp, pv = 1'b0, ev = 1'b0;
  logic rv, rsv, pend, from_rand;
  cmd_kind_type kind;
  logic [7:0] cla, p1, p2, le, len, plen = 8'h05, elen = 8'h03;
  logic [1:0] rch = 2'h1;
  logic [15:0] sw;
  logic [63:0] rrand, refr, r1;
  int fails = 0, total_checks = 0;
  terminal_model term (.mclk_in(mclk_in), .cmd_valid_out(cv),
    .cmd_kind_out(kind), .cla_out(cla), .p1_out(p1), .p2_out(p2),
    .le_out(le), .le_present_out(lp));
  card_apdu_command_handler dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .cmd_valid_in(cv), .cmd_kind_in(kind), .cla_in(cla), .p1_in(p1),
    .p2_in(p2), .le_in(le), .le_present_in(lp), .proactive_valid_in(pv),
    .proactive_len_in(plen), .envelope_len_valid_in(ev),
    .envelope_len_in(elen), .ref_chan_in(rch), .ref_rand_out(refr),
    .ref_rand_valid_out(rsv), .resp_valid_out(rv), .resp_sw_out(sw),
    .resp_len_out(len), .resp_from_rand_out(from_rand),
    .resp_rand_out(rrand), .pend_valid_out(pend));
  // 125 mhz clock
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  task automatic chk(input string nm, input logic [63:0] e, g);
    total_checks++;
    if (e !== g) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one command, then its answer in the cycle after it is taken
  task automatic run(input cmd_kind_type k, input logic [7:0] c,
    input logic bad, input logic [7:0] l, input logic p,
    input logic [15:0] esw, input logic [7:0] elen_x);
    term.issue(k, c, bad, l, p);
    chk("resp_valid", 1, rv);
    chk("resp_sw", esw, sw);
    chk("resp_len", elen_x, len);
  endtask : run
  task automatic test_first;
    run(cmd_get_resp_type, 8'h00, 0, 8'h00, 1, SW_TECH_PROBLEM, 0);
    $display("test_first done");
  endtask : test_first
  task automatic test_challenge;
    run(cmd_challenge_type, 8'h01, 0, 8'h04, 1, 16'h6104, 0);
    chk("pend", 1, pend);
    r1 = refr;
    run(cmd_challenge_type, 8'h01, 0, LE_ZERO, 1, 16'h6108, 0);
    chk("fresh", 1, refr !== r1);
    r1 = refr;
    run(cmd_get_resp_type, 8'h01, 0, 8'h00, 1, SW_OK, 8'h08);
    chk("from_rand", 1, from_rand);
    chk("rand", r1, rrand);
    chk("kept_valid", 1, rsv);
    chk("kept", r1, refr);
    $display("test_challenge done");
  endtask : test_challenge
  task automatic test_refuse;
    for (int k = 1; k < 7; k++) begin
      run(cmd_kind_type'(k), 8'h00, 1, 8'h00, 1, SW_WRONG_PARAM, 0);
      chk("pend_refused", 0, pend);
    end
    $display("test_refuse done");
  endtask : test_refuse
  task automatic test_toolkit;
    run(cmd_profile_type, 8'h00, 0, 8'h00, 0, SW_OK, 0);
    run(cmd_term_resp_type, 8'h00, 0, 8'h00, 0, SW_OK, 0);
    run(cmd_fetch_type, 8'h00, 0, 8'h05, 1, SW_OK, 0);
    pv = 1'b1;
    run(cmd_fetch_type, 8'h00, 0, 8'h05, 1, 16'h6105, 0);
    run(cmd_get_resp_type, 8'h00, 0, 8'h00, 1, SW_OK, 8'h05);
    pv = 1'b0;
    ev = 1'b1;
    run(cmd_envelope_type, 8'h00, 0, 8'h00, 0, 16'h6103, 0);
    run(cmd_get_resp_type, 8'h00, 0, 8'h03, 1, SW_OK, 8'h03);
    ev = 1'b0;
    $display("test_toolkit done");
  endtask : test_toolkit
  task automatic test_sequence;
    run(cmd_challenge_type, 8'h02, 0, 8'h00, 1, 16'h6108, 0);
    // the number must land on channel 2 only, channel 3 saw no challenge
    rch = 2'h2;
    #1;
    chk("chan_bound", 1, rsv);
    @(posedge mclk_in);
    #1;
    rch = 2'h3;
    #1;
    chk("chan_other", 0, rsv);
    run(cmd_profile_type, 8'h03, 0, 8'h00, 0, SW_OK, 0);
    run(cmd_get_resp_type, 8'h02, 0, 8'h00, 1, SW_TECH_PROBLEM, 0);
    run(cmd_challenge_type, 8'h00, 0, 8'h00, 1, 16'h6108, 0);
    run(cmd_profile_type, 8'h00, 0, 8'h00, 0, SW_OK, 0);
    run(cmd_get_resp_type, 8'h00, 0, 8'h00, 1, SW_TECH_PROBLEM, 0);
    $display("test_sequence done");
  endtask : test_sequence
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // the tests need well under a thousand cycles
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    #1;
    reset_n_in = 1'b1;
    test_first();
    test_challenge();
    test_refuse();
    test_toolkit();
    test_sequence();
    give_verdict();
  end
endmodule : tb
